// ==== hw/cst_route.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cst_defines.svh"

module cst_route
  import cst_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic ce_in,
  cst_if.route      rt
);

  typedef struct packed {
    logic                 osc_en;
    logic                 src_en;
    logic [`CST_CH_N-1:0] onehot;
    logic                 t0_tick;
  } cst_route_state_s;

  cst_route_state_s q, d;

  always_comb
  begin
    d = q;
    // Fixed mode with no range stops the oscillator; sleep does not
    d.osc_en = rt.ctrl.enable &&
               (rt.ctrl.ref_mode || rt.ctrl.range != `CST_RANGE_NONE);
    // Variable mode with no range: noise detect, pin source off
    d.src_en = d.osc_en && rt.ctrl.range != `CST_RANGE_NONE;
    d.onehot = rt.ctrl.enable ? (`CST_CH_N'(1) << rt.channel)
                              : `CST_CH_N'(0);
    d.t0_tick = rt.osc_rise && rt.ctrl.enable && rt.ctrl.t0_ext_sel &&
                !rt.t0_cs && !rt.sleep;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      q <= '0;
    end
    else if (ce_in)
    begin
      q <= d;
    end
  end

  assign rt.osc_en      = q.osc_en;
  assign rt.src_en      = q.src_en;
  assign rt.chan_onehot = q.onehot;
  assign rt.t0_tick     = q.t0_tick;
  assign rt.t1_osc_sel  = rt.t1_cs == `CST_T1CS_OSC;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  a_chan_off_disabled: assert property (ce_in && !rt.ctrl.enable |=> q.onehot == '0)
    else $error("channel connected while unit disabled");
  a_t0_sleep_stop: assert property (ce_in && rt.sleep |=> !q.t0_tick)
    else $error("timer0 tick during sleep");
  a_t0_osc_route: assert property (ce_in && rt.osc_rise && rt.ctrl.enable &&
      rt.ctrl.t0_ext_sel && !rt.t0_cs && !rt.sleep |=> q.t0_tick)
    else $error("oscillator edge not routed to timer0");
  a_osc_fixed_off: assert property (ce_in && !rt.ctrl.ref_mode &&
      rt.ctrl.range == `CST_RANGE_NONE |=> !q.osc_en)
    else $error("oscillator running in fixed mode with no range");
  a_osc_sleep_run: assert property (ce_in && rt.ctrl.enable && rt.sleep &&
      rt.ctrl.range != `CST_RANGE_NONE |=> q.osc_en && q.src_en)
    else $error("oscillator stopped during sleep");

endmodule

`default_nettype wire

// ==== hw/cst_top.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "cst_defines.svh"

module cst_top
  import cst_pkg::*;
#(
  parameter int T1_W = `CST_T1_W
)
(
  input  wire logic                   clk_in,
  input  wire logic                   srst_in,
  input  wire logic                   ce_in,
  input  wire logic [`CST_ADDR_W-1:0] avs_address_in,
  input  wire logic                   avs_read_in,
  input  wire logic                   avs_write_in,
  input  wire logic [`CST_DATA_W-1:0] avs_writedata_in,
  input  wire logic [`CST_BE_W-1:0]   avs_byteenable_in,
  output logic      [`CST_DATA_W-1:0] avs_readdata_out,
  output logic                        avs_waitrequest_out,
  input  wire logic                   osc_in,
  input  wire logic                   gate_in,
  input  wire logic                   sleep_in,
  output logic                        osc_enable_out,
  output logic                        source_current_en_out,
  output logic                        ref_mode_out,
  output logic      [1:0]             current_range_out,
  output logic      [`CST_CH_N-1:0]   channel_connect_out,
  output logic                        timer0_tick_out,
  output logic      [T1_W-1:0]        timer1_count_out
);

  typedef struct packed {
    cst_bus_e             bus;
    cst_word_t            rdata;
    cst_ctrl0_s           ctrl;
    logic [`CST_CH_W-1:0] channel;
    cst_troute_s          troute;
    logic                 osc;
    logic [T1_W-1:0]      t1_cnt;
  } cst_top_state_s;

  cst_top_state_s q, d;

  logic      req;
  logic      osc_rise;
  logic      t1_tick;
  cst_word_t ctrl0_word;
  cst_word_t troute_word;

  cst_if u_if ();

  // Bus request, oscillator rising edge and timer1 count enable
  always_comb
  begin
    req      = avs_read_in || avs_write_in;
    osc_rise = osc_in && !q.osc;
    t1_tick  = osc_rise && q.ctrl.enable && u_if.t1_osc_sel &&
               q.troute.t1_on && (!q.troute.t1_ge || gate_in);
  end

  // Register images as software sees them
  always_comb
  begin
    ctrl0_word                 = `CST_WORD_RST;
    ctrl0_word[`CST_B_ENABLE]  = q.ctrl.enable;
    ctrl0_word[`CST_B_REFMODE] = q.ctrl.ref_mode;
    ctrl0_word[`CST_B_RNG_HI:`CST_B_RNG_LO] = q.ctrl.range;
    ctrl0_word[`CST_B_STATUS]  = q.osc;
    ctrl0_word[`CST_B_T0XSEL]  = q.ctrl.t0_ext_sel;
    troute_word                = `CST_WORD_RST;
    troute_word[`CST_B_T0CS]   = q.troute.t0_cs;
    troute_word[`CST_B_T1CS_HI:`CST_B_T1CS_LO] = q.troute.t1_cs;
    troute_word[`CST_B_T1ON]   = q.troute.t1_on;
    troute_word[`CST_B_T1GE]   = q.troute.t1_ge;
  end

  // Bus slave and timer1 counter
  always_comb
  begin
    cst_word_t nw;
    nw = `CST_WORD_RST;
    d = q;
    d.osc = osc_in;
    if (t1_tick)
    begin
      d.t1_cnt = q.t1_cnt + T1_W'(1);
    end
    case (q.bus)
      CST_BUS_IDLE:
      begin
        if (req)
        begin
          d.bus = CST_BUS_ACK;
          case (avs_address_in)
            `CST_OFF_CTRL0:  d.rdata = ctrl0_word;
            `CST_OFF_CTRL1:  d.rdata = cst_word_t'(q.channel);
            `CST_OFF_TROUTE: d.rdata = troute_word;
            `CST_OFF_T1CNT:  d.rdata = cst_word_t'(q.t1_cnt);
            default:         d.rdata = `CST_WORD_RST;
          endcase
        end
      end
      CST_BUS_ACK:
      begin
        d.bus = CST_BUS_IDLE;
        if (avs_write_in)
        begin
          case (avs_address_in)
            `CST_OFF_CTRL0:
            begin
              // Status position is not stored, so writes to it vanish
              nw = cst_merge(ctrl0_word, avs_writedata_in, avs_byteenable_in);
              d.ctrl.enable     = nw[`CST_B_ENABLE];
              d.ctrl.ref_mode   = nw[`CST_B_REFMODE];
              d.ctrl.range      = nw[`CST_B_RNG_HI:`CST_B_RNG_LO];
              d.ctrl.t0_ext_sel = nw[`CST_B_T0XSEL];
            end
            `CST_OFF_CTRL1:
            begin
              nw = cst_merge(cst_word_t'(q.channel), avs_writedata_in,
                             avs_byteenable_in);
              d.channel = nw[`CST_CH_W-1:0];
            end
            `CST_OFF_TROUTE:
            begin
              nw = cst_merge(troute_word, avs_writedata_in, avs_byteenable_in);
              d.troute.t0_cs = nw[`CST_B_T0CS];
              d.troute.t1_cs = nw[`CST_B_T1CS_HI:`CST_B_T1CS_LO];
              d.troute.t1_on = nw[`CST_B_T1ON];
              d.troute.t1_ge = nw[`CST_B_T1GE];
            end
            `CST_OFF_T1CNT:
            begin
              // Software load wins over a count in the same cycle
              nw = cst_merge(cst_word_t'(q.t1_cnt), avs_writedata_in,
                             avs_byteenable_in);
              d.t1_cnt = nw[T1_W-1:0];
            end
            default:
            begin
              nw = `CST_WORD_RST;
            end
          endcase
        end
      end
      default:
      begin
        d.bus = CST_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      q <= '0;
    end
    else if (ce_in)
    begin
      q <= d;
    end
  end

  // Interface to the routing module
  assign u_if.ctrl     = q.ctrl;
  assign u_if.channel  = q.channel;
  assign u_if.t0_cs    = q.troute.t0_cs;
  assign u_if.t1_cs    = q.troute.t1_cs;
  assign u_if.sleep    = sleep_in;
  assign u_if.osc_rise = osc_rise;

  cst_route u_route (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .ce_in   (ce_in),
    .rt      (u_if.route)
  );

  // One wait cycle, released on the edge that completes the access
  assign avs_waitrequest_out   = req && !(q.bus == CST_BUS_ACK && ce_in);
  assign avs_readdata_out      = q.rdata;
  assign osc_enable_out        = u_if.osc_en;
  assign source_current_en_out = u_if.src_en;
  assign ref_mode_out          = q.ctrl.ref_mode;
  assign current_range_out     = q.ctrl.range;
  assign channel_connect_out   = u_if.chan_onehot;
  assign timer0_tick_out       = u_if.t0_tick;
  assign timer1_count_out      = q.t1_cnt;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_req_taken;
    ce_in && req && q.bus == CST_BUS_IDLE;
  endsequence

  sequence s_ctrl0_read;
    s_req_taken ##0 avs_read_in && avs_address_in == `CST_OFF_CTRL0;
  endsequence

  sequence s_count_quiet;
    ce_in && !(q.bus == CST_BUS_ACK && avs_write_in);
  endsequence

  a_bus_one_wait: assert property (s_req_taken ##1 (ce_in && req) |-> !avs_waitrequest_out)
    else $error("waitrequest not released on second cycle");
  a_status_live: assert property (s_ctrl0_read |=>
      avs_readdata_out[`CST_B_STATUS] == $past(q.osc))
    else $error("status bit does not show oscillator level");
  a_reserved_zero: assert property (s_ctrl0_read |=>
      avs_readdata_out[5:4] == 2'h0 && avs_readdata_out[31:8] == 24'h0)
    else $error("reserved control bits not zero");
  a_ctrl_reset: assert property ($fell(srst_in) |->
      q.ctrl == '0 && q.troute == '0 && q.t1_cnt == '0)
    else $error("control state not zero after reset");
  a_t1_off_hold: assert property (s_count_quiet ##0 !q.troute.t1_on |=>
      $stable(q.t1_cnt))
    else $error("timer1 counted while off");
  a_t1_gate_hold: assert property (s_count_quiet ##0 q.troute.t1_ge && !gate_in |=>
      $stable(q.t1_cnt))
    else $error("timer1 counted with gate closed");
  a_t1_osc_count: assert property (s_count_quiet ##0 osc_rise && q.ctrl.enable &&
      q.troute.t1_cs == `CST_T1CS_OSC && q.troute.t1_on && !q.troute.t1_ge |=>
      q.t1_cnt == $past(q.t1_cnt) + T1_W'(1))
    else $error("timer1 missed an oscillator edge");
  a_status_wr_ign: assert property (ce_in && q.bus == CST_BUS_ACK && avs_write_in &&
      avs_address_in == `CST_OFF_CTRL0 |=> q.osc == $past(osc_in))
    else $error("status bit affected by a write");

endmodule

`default_nettype wire

// ==== include/cst_defines.svh ====
`ifndef CST_DEFINES_SVH
`define CST_DEFINES_SVH

// Bus geometry
`define CST_ADDR_W      5
`define CST_DATA_W      32
`define CST_BE_W        4

// Register byte offsets
`define CST_OFF_CTRL0   5'h00
`define CST_OFF_CTRL1   5'h04
`define CST_OFF_TROUTE  5'h08
`define CST_OFF_T1CNT   5'h0C

// sense_control_0 field positions
`define CST_B_ENABLE    7
`define CST_B_REFMODE   6
`define CST_B_RNG_HI    3
`define CST_B_RNG_LO    2
`define CST_B_STATUS    1
`define CST_B_T0XSEL    0

// timer_route field positions
`define CST_B_T0CS      0
`define CST_B_T1CS_HI   2
`define CST_B_T1CS_LO   1
`define CST_B_T1ON      3
`define CST_B_T1GE      4

// Encodings, widths and reset values
`define CST_T1CS_OSC    2'h3
`define CST_RANGE_NONE  2'h0
`define CST_CH_W        3
`define CST_CH_N        8
`define CST_T1_W        16
`define CST_WORD_RST    32'h0000_0000

`endif

// ==== include/cst_if.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cst_defines.svh"

interface cst_if;
  import cst_pkg::*;

  cst_ctrl0_s             ctrl;
  logic [`CST_CH_W-1:0]   channel;
  logic                   t0_cs;
  logic [1:0]             t1_cs;
  logic                   sleep;
  logic                   osc_rise;
  logic                   osc_en;
  logic                   src_en;
  logic [`CST_CH_N-1:0]   chan_onehot;
  logic                   t0_tick;
  logic                   t1_osc_sel;

  modport cfg (
    output ctrl, channel, t0_cs, t1_cs, sleep, osc_rise,
    input  osc_en, src_en, chan_onehot, t0_tick, t1_osc_sel
  );

  modport route (
    input  ctrl, channel, t0_cs, t1_cs, sleep, osc_rise,
    output osc_en, src_en, chan_onehot, t0_tick, t1_osc_sel
  );
endinterface

`default_nettype wire

// ==== include/cst_pkg.sv ====
`include "cst_defines.svh"

package cst_pkg;

  typedef enum logic [0:0] {
    CST_BUS_IDLE = 1'h0,
    CST_BUS_ACK  = 1'h1
  } cst_bus_e;

  typedef struct packed {
    logic       enable;
    logic       ref_mode;
    logic [1:0] range;
    logic       t0_ext_sel;
  } cst_ctrl0_s;

  typedef struct packed {
    logic       t1_ge;
    logic       t1_on;
    logic [1:0] t1_cs;
    logic       t0_cs;
  } cst_troute_s;

  typedef logic [`CST_DATA_W-1:0] cst_word_t;

  // Byte-lane merge of write data into an old word
  function automatic cst_word_t cst_merge(input cst_word_t old_w,
                                          input cst_word_t wd,
                                          input logic [`CST_BE_W-1:0] be);
    cst_word_t r;
    r = old_w;
    for (int i = 0; i < `CST_BE_W; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// ==== verification/cst_pad_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module cst_pad_model
#(
  parameter int HALF = 3
)
(
  input  wire logic clk_in,
  input  wire logic osc_enable_in,
  input  wire logic load_in,
  output logic      osc_out
);
  int   phase_q = 0;
  logic level_q = 1'b0;

  assign osc_out = level_q;

  // Swings while enabled, sleep or not; stands low when stopped
  always @(posedge clk_in)
  begin
    if (!osc_enable_in)
    begin
      phase_q <= 0;
      level_q <= 1'b0;
    end
    // Extra pad load halves the swing rate
    else if (phase_q >= (load_in ? 2 * HALF : HALF) - 1)
    begin
      phase_q <= 0;
      level_q <= ~level_q;
    end
    else
    begin
      phase_q <= phase_q + 1;
    end
  end
endmodule

`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cst_defines.svh"

module testbench;
  import cst_pkg::*;

  logic        clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        ce = 1'b1;
  logic        load = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic        rd_req = 1'b0;
  logic        wr_req = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        gate = 1'b0;
  logic        sleep = 1'b0;
  logic [31:0] rdata;
  logic        wait_r;
  logic        osc;
  logic        osc_en;
  logic        src_en;
  logic        refm;
  logic [1:0]  rng;
  logic [7:0]  chan;
  logic        tick;
  logic [15:0] t1cnt;
  logic        osc_d = 1'b0;
  int          errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          rises = 0;
  int          ticks = 0;

  cst_top uut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce), .avs_address_in(addr),
    .avs_read_in(rd_req), .avs_write_in(wr_req), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r),
    .osc_in(osc), .gate_in(gate), .sleep_in(sleep), .osc_enable_out(osc_en),
    .source_current_en_out(src_en), .ref_mode_out(refm), .current_range_out(rng),
    .channel_connect_out(chan), .timer0_tick_out(tick), .timer1_count_out(t1cnt));

  cst_pad_model #(.HALF(3)) pad (.clk_in(clk_in), .osc_enable_in(osc_en), .load_in(load),
    .osc_out(osc));

  initial
  begin
    forever #4 clk_in = ~clk_in;
  end

  task automatic end_of_test();
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Cumulative oscillator rises and timer0 ticks, plus the hang limit
  always @(posedge clk_in)
  begin
    cycles++;
    osc_d <= osc;
    if (osc === 1'b1 && osc_d === 1'b0)
      rises++;
    if (tick === 1'b1)
      ticks++;
    if (cycles == 20000)
    begin
      errors++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_in);
    addr <= a;
    wdata <= wd;
    wr_req <= wr;
    rd_req <= !wr;
    @(posedge clk_in);
    while (wait_r !== 1'b0)
    begin
      @(posedge clk_in);
      n++;
    end
    rd = rdata;
    wr_req <= 1'b0;
    rd_req <= 1'b0;
    chk("bus wait", 32'h1, 32'(n));
  endtask

  logic [31:0] rv;
  logic [9:0]  c;
  logic [2:0]  m;
  logic        seen0;
  logic        seen1;
  int          r0;
  int          k0;
  logic [31:0] meas [2];
  logic [31:0] thr;
  // {ext sel, sleep, gate, route[4:0], timer0 expected, timer1 expected}
  logic [9:0]  cases [10] = '{10'h202, 10'h204, 10'h000, 10'h039, 10'h078,
                              10'h0F9, 10'h018, 10'h030, 10'h300, 10'h139};

  initial
  begin
    repeat (8) @(posedge clk_in);
    srst_in <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b0, 5'(i * 4), 32'h0, rv);
      chk("reset value", 32'h0, rv);
    end
    bus(1'b1, 5'h10, 32'hFFFFFFFF, rv);
    bus(1'b0, 5'h10, 32'h0, rv);
    chk("unmapped", 32'h0, rv);
    bus(1'b1, `CST_OFF_CTRL0, 32'hFF, rv);
    bus(1'b0, `CST_OFF_CTRL0, 32'h0, rv);
    chk("control full", 32'hCD, rv & ~32'h2);
    bus(1'b1, `CST_OFF_CTRL0, 32'h02, rv);
    repeat (4) @(posedge clk_in);
    bus(1'b0, `CST_OFF_CTRL0, 32'h0, rv);
    chk("status write", 32'h0, rv);
    for (int i = 0; i < 8; i++)
    begin
      m = 3'(i);
      bus(1'b1, `CST_OFF_CTRL0, {24'h0, 1'b1, m[2], 2'h0, m[1:0], 2'h0}, rv);
      repeat (2) @(posedge clk_in);
      chk("ref mode", {31'h0, m[2]}, {31'h0, refm});
      chk("range", {30'h0, m[1:0]}, {30'h0, rng});
      chk("osc enable", {31'h0, m[2] || m[1:0] != 2'h0}, {31'h0, osc_en});
      chk("source enable", {31'h0, m[1:0] != 2'h0}, {31'h0, src_en});
    end
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, `CST_OFF_CTRL1, 32'(i), rv);
      repeat (2) @(posedge clk_in);
      chk("channel", 32'h1 << i, {24'h0, chan});
    end
    seen0 = 1'b0;
    seen1 = 1'b0;
    for (int i = 0; i < 12; i++)
    begin
      bus(1'b0, `CST_OFF_CTRL0, 32'h0, rv);
      seen1 = seen1 | rv[1];
      seen0 = seen0 | !rv[1];
    end
    chk("status swing", 32'h3, {30'h0, seen1, seen0});
    bus(1'b1, `CST_OFF_CTRL0, 32'h0, rv);
    repeat (2) @(posedge clk_in);
    chk("channel off", 32'h0, {24'h0, chan});
    foreach (cases[i])
    begin
      c = cases[i];
      sleep <= c[8];
      gate <= c[7];
      bus(1'b1, `CST_OFF_CTRL0, {24'h0, 7'h40, c[9]}, rv);
      bus(1'b1, `CST_OFF_TROUTE, {27'h0, c[6:2]}, rv);
      bus(1'b1, `CST_OFF_T1CNT, 32'h0, rv);
      repeat (4) @(posedge clk_in);
      r0 = rises;
      k0 = ticks;
      bus(1'b1, `CST_OFF_CTRL0, {24'h0, 7'h42, c[9]}, rv);
      repeat (60) @(posedge clk_in);
      bus(1'b1, `CST_OFF_CTRL0, {24'h0, 7'h40, c[9]}, rv);
      repeat (4) @(posedge clk_in);
      chk("osc ran", 32'h1, {31'h0, rises != r0});
      chk("timer0 ticks", c[1] ? 32'(rises - r0) : 32'h0, 32'(ticks - k0));
      bus(1'b0, `CST_OFF_T1CNT, 32'h0, rv);
      chk("timer1 count", c[0] ? 32'(rises - r0) : 32'h0, rv);
    end
    // Same window, bare pad then loaded pad
    sleep <= 1'b0;
    gate <= 1'b0;
    bus(1'b1, `CST_OFF_TROUTE, 32'h0000000E, rv);
    for (int i = 0; i < 2; i++)
    begin
      load <= (i == 1);
      bus(1'b1, `CST_OFF_T1CNT, 32'h0, rv);
      r0 = rises;
      bus(1'b1, `CST_OFF_CTRL0, 32'h00000084, rv);
      repeat (60) @(posedge clk_in);
      bus(1'b1, `CST_OFF_CTRL0, 32'h00000080, rv);
      repeat (4) @(posedge clk_in);
      bus(1'b0, `CST_OFF_T1CNT, 32'h0, rv);
      chk("window count", 32'(rises - r0), rv);
      meas[i] = rv;
    end
    thr = (meas[0] + meas[1]) / 2;
    chk("threshold split", 32'h1, {31'h0, meas[1] < thr && thr < meas[0]});
    // Clock enable low freezes the count while the pad keeps swinging
    bus(1'b1, `CST_OFF_CTRL0, 32'h00000084, rv);
    repeat (30) @(posedge clk_in);
    ce <= 1'b0;
    @(posedge clk_in);
    rv = {16'h0, t1cnt};
    repeat (20) @(posedge clk_in);
    chk("frozen count", rv, {16'h0, t1cnt});
    chk("count ran", 32'h1, {31'h0, rv != 32'h0});
    chk("frozen osc enable", 32'h1, {31'h0, osc_en});
    ce <= 1'b1;
    bus(1'b1, `CST_OFF_CTRL0, 32'h0, rv);
    end_of_test();
  end
endmodule

`default_nettype wire
